// ==== srm_pkg.sv ====
// constants and types for the switch reset and mode select block
package srm_pkg;

    // ************************************************************
    // widths and reset values
    // ************************************************************
    localparam int          SRM_MODE_W       = 4;
    localparam logic [3:0]  SRM_MODE_RST     = 4'h0;
    localparam logic        SRM_HALT_RST     = 1'b0;
    localparam logic [1:0]  SRM_SYNC_RST     = 2'h0;

    // ************************************************************
    // mode strap codes
    // ************************************************************
    localparam logic [3:0]  SRM_M_SINGLE     = 4'h0;
    localparam logic [3:0]  SRM_M_SINGLE_EE  = 4'h1;
    localparam logic [3:0]  SRM_M_SINGLE_J0  = 4'h2;
    localparam logic [3:0]  SRM_M_SINGLE_J1  = 4'h3;
    localparam logic [3:0]  SRM_M_RSV_LO     = 4'h4;
    localparam logic [3:0]  SRM_M_RSV_HI     = 4'h7;
    localparam logic [3:0]  SRM_M_LOWLAT     = 4'h8;
    localparam logic [3:0]  SRM_M_LOWLAT_EE  = 4'h9;
    localparam logic [3:0]  SRM_M_UNATT      = 4'hA;
    localparam logic [3:0]  SRM_M_UNATT_I2C  = 4'hB;
    localparam logic [3:0]  SRM_M_UNATT_EE   = 4'hC;
    localparam logic [3:0]  SRM_M_UNATT_BOTH = 4'hD;
    localparam logic [3:0]  SRM_M_DISAB      = 4'hE;
    localparam logic [3:0]  SRM_M_DISAB_EE   = 4'hF;

    // ************************************************************
    // eeprom start point encoding
    // ************************************************************
    localparam logic [1:0]  SRM_EE_NONE      = 2'h0;
    localparam logic [1:0]  SRM_EE_BASE      = 2'h1;
    localparam logic [1:0]  SRM_EE_JUMP0     = 2'h2;
    localparam logic [1:0]  SRM_EE_JUMP1     = 2'h3;

    // ************************************************************
    // sequencer states
    // ************************************************************
    typedef enum logic [1:0] {
        SRM_RESET = 2'b00,
        SRM_CAPT  = 2'b01,
        SRM_HALT  = 2'b10,
        SRM_RUN   = 2'b11
    } srm_state_t;

endpackage

// ==== srm_top.sv ====
// reset sequencer and mode strap decoder of the switch
//
// Notes on behaviour
// [RULE_01] Fundamental reset low puts all block state back to reset; mode_q and the decode outputs keep their values.
// [RULE_02] Hold request seen at reset release parks the switch in quasi-reset with both management buses on.
// [RULE_03] In quasi-reset the register path is open but switching stays off.
// [RULE_04] Clearing the halt control bit over management leaves quasi-reset and starts switching.
// [RULE_05] The board keeps the mode strap unchanged after reset release.
// [RULE_06] Codes 0 to 3 give single partition, plain, eeprom, jump 0 and jump 1.
// [RULE_07] The board never straps the reserved codes 4 to 7.
// [RULE_08] Codes 8 and 9 give single partition reduced latency, plain or with eeprom.
// [RULE_09] Codes A to D give multi-partition unattached ports, plain, i2c reset, eeprom, both.
// [RULE_10] Codes E and F give multi-partition disabled ports, plain or with eeprom.
// [RULE_11] Strap and hold request are captured once at reset release and kept.
`timescale 1ns/1ns
module srm_top
    import srm_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        fundamental_reset_n,
    input  wire logic        reset_hold_request,
    input  wire logic [3:0]  operating_mode_strap,
    input  wire logic        halt_clear,
    output logic             core_reset_n,
    output logic             mgmt_bus_enable,
    output logic             reg_access_enable,
    output logic             switch_run,
    output logic             quasi_reset,
    output logic [3:0]       mode_q,
    output logic             multi_partition,
    output logic             reduced_latency,
    output logic             ports_disabled,
    output logic             i2c_reset_en,
    output logic [1:0]       eeprom_start,
    output logic             mode_reserved
);

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [2:0]  prst_sync_q;
    logic [2:0]  hold_sync_q;
    logic        prst_ok;
    logic        hold_ok;
    srm_state_t  state_q;
    logic        switch_control_reg_q;   // halt control bit

    // three stages; the first is only read by the second
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prst_sync_q <= 3'h0;
            hold_sync_q <= 3'h0;
        end else begin
            prst_sync_q <= {prst_sync_q[1:0], fundamental_reset_n};
            hold_sync_q <= {hold_sync_q[1:0], reset_hold_request};
        end
    end

    // level counts once stage two and three agree
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prst_ok <= 1'b0;
            hold_ok <= 1'b0;
        end else begin
            if (prst_sync_q[2] == prst_sync_q[1]) begin
                prst_ok <= prst_sync_q[2];
            end
            if (hold_sync_q[2] == hold_sync_q[1]) begin
                hold_ok <= hold_sync_q[2];
            end
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    // [RULE_01] reset on assertion
    // [RULE_04] halt clear releases
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SRM_RESET;
        end else if (!prst_ok) begin
            state_q <= SRM_RESET;
        end else begin
            unique case (state_q)
                SRM_RESET: begin
                    state_q <= SRM_CAPT;
                end
                SRM_CAPT: begin
                    state_q <= hold_ok ? SRM_HALT : SRM_RUN;
                end
                SRM_HALT: begin
                    if (halt_clear) begin
                        state_q <= SRM_RUN;
                    end
                end
                SRM_RUN: begin
                    state_q <= SRM_RUN;
                end
            endcase
        end
    end

    // [RULE_11] capture at release
    // [RULE_02] halt bit from hold request
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q               <= SRM_MODE_RST;
            switch_control_reg_q <= SRM_HALT_RST;
        end else if (!prst_ok) begin
            switch_control_reg_q <= SRM_HALT_RST;
        end else if (state_q == SRM_RESET) begin
            mode_q               <= operating_mode_strap;
            switch_control_reg_q <= hold_ok;
        end else if (state_q == SRM_HALT && halt_clear) begin
            switch_control_reg_q <= 1'b0;
        end
    end

    // ************************************************************
    // reset and run outputs
    // ************************************************************
    // [RULE_02] buses live in quasi-reset
    // [RULE_03] registers open, no switching
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            core_reset_n      <= 1'b0;
            mgmt_bus_enable   <= 1'b0;
            reg_access_enable <= 1'b0;
            switch_run        <= 1'b0;
            quasi_reset       <= 1'b0;
        end else begin
            core_reset_n      <= prst_ok && (state_q == SRM_RUN);
            mgmt_bus_enable   <= prst_ok && (state_q == SRM_HALT ||
                                             state_q == SRM_RUN);
            reg_access_enable <= prst_ok && (state_q == SRM_HALT ||
                                             state_q == SRM_RUN);
            switch_run        <= prst_ok && (state_q == SRM_RUN);
            quasi_reset       <= prst_ok && (state_q == SRM_HALT);
        end
    end

    // ************************************************************
    // mode decode
    // ************************************************************
    logic        dec_multi;
    logic        dec_lowlat;
    logic        dec_disab;
    logic        dec_i2c;
    logic [1:0]  dec_ee;
    logic        dec_rsv;

    // [RULE_06] [RULE_08] [RULE_09] [RULE_10] code table
    always_comb begin
        dec_multi  = 1'b0;
        dec_lowlat = 1'b0;
        dec_disab  = 1'b0;
        dec_i2c    = 1'b0;
        dec_ee     = SRM_EE_NONE;
        dec_rsv    = 1'b0;
        unique case (mode_q)
            SRM_M_SINGLE:     dec_ee = SRM_EE_NONE;
            SRM_M_SINGLE_EE:  dec_ee = SRM_EE_BASE;
            SRM_M_SINGLE_J0:  dec_ee = SRM_EE_JUMP0;
            SRM_M_SINGLE_J1:  dec_ee = SRM_EE_JUMP1;
            4'h4, 4'h5, 4'h6, SRM_M_RSV_HI: dec_rsv = 1'b1;
            SRM_M_LOWLAT:     dec_lowlat = 1'b1;
            SRM_M_LOWLAT_EE: begin
                dec_lowlat = 1'b1;
                dec_ee     = SRM_EE_BASE;
            end
            SRM_M_UNATT:      dec_multi = 1'b1;
            SRM_M_UNATT_I2C: begin
                dec_multi = 1'b1;
                dec_i2c   = 1'b1;
            end
            SRM_M_UNATT_EE: begin
                dec_multi = 1'b1;
                dec_ee    = SRM_EE_BASE;
            end
            SRM_M_UNATT_BOTH: begin
                dec_multi = 1'b1;
                dec_i2c   = 1'b1;
                dec_ee    = SRM_EE_BASE;
            end
            SRM_M_DISAB: begin
                dec_multi = 1'b1;
                dec_disab = 1'b1;
            end
            SRM_M_DISAB_EE: begin
                dec_multi = 1'b1;
                dec_disab = 1'b1;
                dec_ee    = SRM_EE_BASE;
            end
        endcase
    end

    // [RULE_07] reserved codes flagged
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            multi_partition <= 1'b0;
            reduced_latency <= 1'b0;
            ports_disabled  <= 1'b0;
            i2c_reset_en    <= 1'b0;
            eeprom_start    <= SRM_EE_NONE;
            mode_reserved   <= 1'b0;
        end else begin
            multi_partition <= dec_multi;
            reduced_latency <= dec_lowlat;
            ports_disabled  <= dec_disab;
            i2c_reset_en    <= dec_i2c;
            eeprom_start    <= dec_ee;
            mode_reserved   <= dec_rsv;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_reset_clears;
        @(posedge mclk) disable iff (!rst_n)
        !prst_ok |=> !switch_run && !quasi_reset;
    endproperty
    a_reset_clears: assert property (p_reset_clears) // [RULE_01]
        else $error("switch active during fundamental reset");

    property p_halt_enter;
        @(posedge mclk) disable iff (!rst_n)
        prst_ok && state_q == SRM_CAPT && hold_ok |=> ##1 quasi_reset;
    endproperty
    a_halt_enter: assert property (p_halt_enter) // [RULE_02]
        else $error("hold request did not enter quasi-reset");

    property p_halt_buses;
        @(posedge mclk) disable iff (!rst_n)
        quasi_reset |-> mgmt_bus_enable && reg_access_enable && !switch_run;
    endproperty
    a_halt_buses: assert property (p_halt_buses) // [RULE_03]
        else $error("quasi-reset bus or run state wrong");

    sequence s_halted_clear;
        prst_ok && state_q == SRM_HALT && halt_clear;
    endsequence
    property p_halt_exit;
        @(posedge mclk) disable iff (!rst_n)
        s_halted_clear ##1 prst_ok |=> switch_run && !quasi_reset;
    endproperty
    a_halt_exit: assert property (p_halt_exit) // [RULE_04]
        else $error("halt clear did not start switching");

    property p_mode_kept;
        @(posedge mclk) disable iff (!rst_n)
        state_q != SRM_RESET && $past(state_q) != SRM_RESET
            |-> $stable(mode_q);
    endproperty
    a_mode_kept: assert property (p_mode_kept) // [RULE_11]
        else $error("captured mode changed after release");

    property p_single_modes;
        @(posedge mclk) disable iff (!rst_n)
        mode_q == SRM_M_SINGLE_J1 |=> !multi_partition &&
            eeprom_start == SRM_EE_JUMP1;
    endproperty
    a_single_modes: assert property (p_single_modes) // [RULE_06]
        else $error("jump 1 decode wrong");

    property p_lowlat;
        @(posedge mclk) disable iff (!rst_n)
        mode_q == SRM_M_LOWLAT_EE |=> reduced_latency &&
            eeprom_start == SRM_EE_BASE && !multi_partition;
    endproperty
    a_lowlat: assert property (p_lowlat) // [RULE_08]
        else $error("reduced latency decode wrong");

    property p_unatt;
        @(posedge mclk) disable iff (!rst_n)
        mode_q == SRM_M_UNATT_BOTH |=> multi_partition && i2c_reset_en &&
            !ports_disabled && eeprom_start == SRM_EE_BASE;
    endproperty
    a_unatt: assert property (p_unatt) // [RULE_09]
        else $error("unattached both decode wrong");

    property p_disab;
        @(posedge mclk) disable iff (!rst_n)
        mode_q == SRM_M_DISAB |=> multi_partition && ports_disabled &&
            !i2c_reset_en && eeprom_start == SRM_EE_NONE;
    endproperty
    a_disab: assert property (p_disab) // [RULE_10]
        else $error("disabled ports decode wrong");

endmodule

// ==== srm_board.sv ====
// board reset logic and management master model for the reset block
`timescale 1ns/1ns
module srm_board (
    input  wire logic        mclk,
    output logic             fundamental_reset_n,
    output logic             reset_hold_request,
    output logic [3:0]       operating_mode_strap,
    output logic             halt_clear
);
    // power up with the switch held in fundamental reset
    initial begin
        fundamental_reset_n  = 1'b0;
        reset_hold_request   = 1'b0;
        operating_mode_strap = 4'h0;
        halt_clear           = 1'b0;
    end

    // ************************************************************
    // reset pin and strap drive
    // ************************************************************
    // pull reset low and set the strap and hold levels
    task automatic assert_reset(input logic [3:0] code, input logic hold);
        logic [3:0] c;
        c = code;
        if (c inside {[4'h4:4'h7]})
            c = 4'h0;
        @(posedge mclk);
        fundamental_reset_n  <= 1'b0;
        operating_mode_strap <= c;
        reset_hold_request   <= hold;
    endtask

    // strap left untouched from release on
    task automatic release_reset();
        @(posedge mclk);
        fundamental_reset_n <= 1'b1;
    endtask

    // full reset cycle of seven cycles low
    task automatic reset_cycle(input logic [3:0] code, input logic hold);
        assert_reset(code, hold);
        repeat (6) @(posedge mclk);
        release_reset();
    endtask

    // hold request goes away after capture
    task automatic drop_hold();
        @(posedge mclk);
        reset_hold_request <= 1'b0;
    endtask

    // ************************************************************
    // management master action
    // ************************************************************
    // one cycle pulse clears the halt bit
    task automatic pulse_clear();
        @(posedge mclk);
        halt_clear <= 1'b1;
        @(posedge mclk);
        halt_clear <= 1'b0;
    endtask
endmodule

// ==== test_srm_top.sv ====
// self-checking testbench of the switch reset and mode select block
`timescale 1ns/1ns
module test_srm_top;
    import srm_pkg::*;
    logic        mclk;
    logic        rst_n;
    logic        frst_n;
    logic        hold;
    logic [3:0]  strap;
    logic        hclr;
    logic        core_reset_n;
    logic        mgmt_bus_enable;
    logic        reg_access_enable;
    logic        switch_run;
    logic        quasi_reset;
    logic [3:0]  mode_q;
    logic        multi_partition;
    logic        reduced_latency;
    logic        ports_disabled;
    logic        i2c_reset_en;
    logic [1:0]  eeprom_start;
    logic        mode_reserved;
    int          fail_count;
    int          cmp_count;
    logic [15:0] dec_now;
    logic [15:0] sts_now;

    // ************************************************************
    // clock, instances, observed groups
    // ************************************************************
    initial mclk = 1'b0;
    always #10 mclk = ~mclk;
    srm_board board (.mclk(mclk), .fundamental_reset_n(frst_n),
        .reset_hold_request(hold), .operating_mode_strap(strap),
        .halt_clear(hclr));
    srm_top dut (.mclk(mclk), .rst_n(rst_n), .fundamental_reset_n(frst_n),
        .reset_hold_request(hold), .operating_mode_strap(strap),
        .halt_clear(hclr), .core_reset_n(core_reset_n),
        .mgmt_bus_enable(mgmt_bus_enable),
        .reg_access_enable(reg_access_enable), .switch_run(switch_run),
        .quasi_reset(quasi_reset), .mode_q(mode_q),
        .multi_partition(multi_partition),
        .reduced_latency(reduced_latency),
        .ports_disabled(ports_disabled), .i2c_reset_en(i2c_reset_en),
        .eeprom_start(eeprom_start), .mode_reserved(mode_reserved));
    assign dec_now = {4'h0, mode_q, multi_partition, reduced_latency,
                      ports_disabled, i2c_reset_en, eeprom_start, mode_reserved};
    assign sts_now = {11'h000, core_reset_n, mgmt_bus_enable,
                      reg_access_enable, switch_run, quasi_reset};

    // ************************************************************
    // helpers
    // ************************************************************
    // expected decode: mode, multi, lowlat, disabled, i2c, eeprom, rsv
    function automatic logic [15:0] exp_dec(input logic [3:0] c);
        logic [5:0] f;
        case (c)
            4'h1: f = 6'h02;     4'h2: f = 6'h04;     4'h3: f = 6'h06;
            4'h8: f = 6'h10;     4'h9: f = 6'h12;     4'hA: f = 6'h20;
            4'hB: f = 6'h21;     4'hC: f = 6'h22;     4'hD: f = 6'h23;
            4'hE: f = 6'h28;     4'hF: f = 6'h2A;     default: f = 6'h00;
        endcase
        return {4'h0, c, f[5:3], f[0], f[2:1], 1'b0};
    endfunction

    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // bounded wait for the management buses to come up
    task automatic wait_up();
        int n;
        n = 0;
        while (mgmt_bus_enable !== 1'b1 && n < 30) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk({15'h0, mgmt_bus_enable}, 16'h0001);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    // every legal strap code decoded and running
    task automatic test_modes();
        logic [3:0] codes [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9,
                                   4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
        foreach (codes[i]) begin
            board.reset_cycle(codes[i], 1'b0);
            wait_up();
            chk(sts_now, 16'h001E);
            chk(dec_now, exp_dec(codes[i]));
        end
        $display("test_modes finished");
    endtask

    // halt at release, hold drop ignored, clear starts switching
    task automatic test_halt();
        board.reset_cycle(4'hD, 1'b1);
        wait_up();
        chk(sts_now, 16'h000D);
        board.drop_hold();
        repeat (6) @(posedge mclk);
        #1;
        chk(sts_now, 16'h000D);
        chk({15'h0, switch_run}, 16'h0000);
        board.pulse_clear();
        repeat (2) @(posedge mclk);
        #1;
        chk(sts_now, 16'h001E);
        chk(dec_now, exp_dec(4'hD));
        $display("test_halt finished");
    endtask

    // clear while running ignored, then reset in mid run
    task automatic test_reset_mid();
        board.pulse_clear();
        repeat (3) @(posedge mclk);
        #1;
        chk(sts_now, 16'h001E);
        board.assert_reset(4'h9, 1'b0);
        repeat (8) @(posedge mclk);
        #1;
        chk(sts_now, 16'h0000);
        board.release_reset();
        wait_up();
        chk(dec_now, exp_dec(4'h9));
        $display("test_reset_mid finished");
    endtask

    // ************************************************************
    // verdict, watchdog, main sequence
    // ************************************************************
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // about 230 cycles expected, limit far above that
    initial begin
        #200000;
        fail_count++;
        report_and_stop();
    end

    initial begin
        fail_count = 0;
        cmp_count  = 0;
        rst_n      = 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        test_modes();
        test_halt();
        test_reset_mid();
        report_and_stop();
    end
endmodule
